// ==== bench/clocked_serial_buffer_port_test.sv ====
`timescale 1ns/1ns
`include "csbp_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
	$display("mismatch %0t got %h exp %h", $time, g, e); end end

module clocked_serial_buffer_port_test;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        serial_out;
	logic        serial_in;
	logic        sck_out;
	logic        sck_oe_n;
	logic        low_freq_clock = 1'b0;
	logic        ext_sck = 1'b1;
	logic        sck_line;
	logic        serial_done_interrupt;
	logic        load = 1'b0;
	logic [63:0] tx_data = 64'h0;
	logic [63:0] prx;
	logic [6:0]  prx_n;
	logic [31:0] rv;
	logic        ev;
	logic [63:0] ex;
	logic        meas = 1'b0;
	int          hi_run = 0;
	int          hi_max = 0;
	int          hm;
	int          dones = 0;
	int          fails = 0;
	int          comparisons = 0;

	always #50 pclk = ~pclk;
	always #400 low_freq_clock = ~low_freq_clock;

	// The pin: driven by the block on internal codes, else by the bench
	assign sck_line = sck_oe_n ? ext_sck : sck_out;

	csbp_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .serial_out(serial_out),
		.serial_in(serial_in), .sck_in(sck_line), .sck_out(sck_out),
		.sck_oe_n(sck_oe_n), .low_freq_clock(low_freq_clock),
		.serial_done_interrupt(serial_done_interrupt));

	csbp_peer peer (.pclk(pclk), .load(load), .tx_data(tx_data),
		.sck_out(sck_line), .serial_out(serial_out),
		.serial_in(serial_in), .rx_q(prx), .rx_n(prx_n));

	// Longest sck high run inside one measured block
	always @(posedge pclk)
	begin
		hi_run <= (sck_out && meas) ? hi_run + 1 : 0;
		if (!meas)
			hi_max <= 0;
		else if (hi_run > hi_max)
			hi_max <= hi_run;
		if (serial_done_interrupt === 1'b1)
			dones++;
	end

	task automatic apb(input logic w, input logic [5:0] idx,
		input logic [31:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			fails++;
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		apb(1'b1, idx, {24'h0, d});
	endtask

	task automatic rd(input logic [5:0] idx);
		apb(1'b0, idx, 32'h0);
	endtask

	task automatic run(input csbp_pkg::csbp_mode_type m,
		input logic [2:0] cnt, input logic [1:0] wt,
		input logic [2:0] ck, input logic [63:0] tx);
		int d0;
		int n;
		load <= 1'b1;
		tx_data <= tx;
		@(posedge pclk);
		load <= 1'b0;
		wr(`CSBP_IDX_MODE, {2'b01, m, ck});
		wr(`CSBP_IDX_CNTW, {3'h0, wt, cnt});
		d0 = dones;
		meas <= 1'b1;
		wr(`CSBP_IDX_MODE, {2'b10, m, ck});
		rd(`CSBP_IDX_CNTW);
		`CHK(rv, 32'hc0)
		wr(`CSBP_IDX_MODE, {2'b00, m, ck});
		n = 0;
		while (dones == d0 && n < 20000)
		begin
			@(posedge pclk);
			n++;
		end
		hm = hi_max;
		meas <= 1'b0;
		repeat (4) @(posedge pclk);
		`CHK(dones - d0, 1)
		rd(`CSBP_IDX_CNTW);
		`CHK(rv, 32'h0)
	endtask

	task automatic t_reset;
		`CHK(sck_out, 1'b1)
		`CHK(sck_oe_n, 1'b0)
		`CHK(serial_done_interrupt, 1'b0)
		rd(`CSBP_IDX_MODE);
		`CHK(rv, 32'h0)
		rd(`CSBP_IDX_CNTW);
		`CHK(rv, 32'h0)
		rd(6'h00);
		`CHK(ev, 1'b1)
	endtask

	task automatic t_tx;
		for (int i = 0; i < 8; i++)
		begin
			ex[8*i +: 8] = 8'h5a ^ 8'(8'h13 * i);
			wr(6'(`CSBP_IDX_BUF0 + i), ex[8*i +: 8]);
		end
		run(csbp_pkg::CSBP_TX8, 3'h7, 2'b01, 3'h5, 64'h0);
		`CHK(prx_n, 7'd64)
		`CHK(prx, ex)
		`CHK(hm < 32, 1'b1)
		run(csbp_pkg::CSBP_TX4, 3'h2, 2'b00, 3'h5, 64'h0);
		`CHK(prx_n, 7'd12)
		`CHK(prx[63:52], {ex[19:16], ex[11:8], ex[3:0]})
	endtask

	task automatic t_rx;
		run(csbp_pkg::CSBP_RX8, 3'h1, 2'b01, 3'h5, 64'hb4a5);
		`CHK(hm >= 120 && hm <= 160, 1'b1)
		rd(`CSBP_IDX_BUF0);
		`CHK(rv, 32'ha5)
		rd(`CSBP_IDX_BUF0 + 6'h1);
		`CHK(rv, 32'hb4)
		rd(`CSBP_IDX_BUF0 + 6'h2);
		`CHK(rv, {24'h0, ex[23:16]})
		run(csbp_pkg::CSBP_RX4, 3'h1, 2'b00, 3'h5, 64'h3c);
		rd(`CSBP_IDX_BUF0);
		`CHK(rv, 32'h0c)
		rd(`CSBP_IDX_BUF0 + 6'h1);
		`CHK(rv, 32'h03)
		wr(`CSBP_IDX_BUF0, 8'h5a);
		run(csbp_pkg::CSBP_TRX8, 3'h0, 2'b00, 3'h5, 64'hc3);
		`CHK(prx[63:56], 8'h5a)
		rd(`CSBP_IDX_BUF0);
		`CHK(rv, 32'hc3)
	endtask

	task automatic t_misc;
		wr(`CSBP_IDX_CFG, 8'h01);
		rd(`CSBP_IDX_CFG);
		`CHK(rv, 32'h1)
		run(csbp_pkg::CSBP_TX8, 3'h0, 2'b00, 3'h0, 64'h0);
		`CHK(hm >= 120 && hm <= 160, 1'b1)
		// Slow mode leaves only code 000 and external; fast codes stay quiet
		wr(`CSBP_IDX_CFG, 8'h02);
		rd(`CSBP_IDX_CFG);
		`CHK(rv, 32'h2)
		wr(`CSBP_IDX_MODE, 8'h45);
		wr(`CSBP_IDX_MODE, 8'h85);
		repeat (100) @(posedge pclk);
		`CHK(sck_out, 1'b1)
		wr(`CSBP_IDX_MODE, 8'h45);
		wr(`CSBP_IDX_CFG, 8'h00);
		// Slowest fc code, so abort lands mid-word
		wr(`CSBP_IDX_MODE, 8'h40);
		wr(`CSBP_IDX_MODE, 8'h80);
		rd(`CSBP_IDX_CNTW);
		`CHK(rv, 32'hc0)
		wr(`CSBP_IDX_MODE, 8'h40);
		rd(`CSBP_IDX_CNTW);
		`CHK(rv, 32'h0)
		`CHK(sck_out, 1'b1)
		wr(`CSBP_IDX_MODE, 8'h5d);
		wr(`CSBP_IDX_MODE, 8'h9d);
		rd(`CSBP_IDX_CNTW);
		`CHK(rv, 32'h0)
		wr(`CSBP_IDX_MODE, 8'h40);
	endtask

	task automatic t_hold;
		int d0;
		d0 = dones;
		wr(`CSBP_IDX_MODE, 8'h45);
		wr(`CSBP_IDX_CNTW, 8'h00);
		wr(`CSBP_IDX_MODE, 8'h85);
		repeat (200) @(posedge pclk);
		rd(`CSBP_IDX_CNTW);
		`CHK(rv, 32'h80)
		rd(`CSBP_IDX_BUF0);
		repeat (200) @(posedge pclk);
		`CHK(dones - d0, 2)
		wr(`CSBP_IDX_MODE, 8'h05);
		rd(`CSBP_IDX_CNTW);
		`CHK(rv, 32'h0)
	endtask

	task automatic t_ext;
		int d0;
		load <= 1'b1;
		@(posedge pclk);
		load <= 1'b0;
		wr(`CSBP_IDX_MODE, 8'h47);
		wr(`CSBP_IDX_CNTW, 8'h00);
		d0 = dones;
		wr(`CSBP_IDX_MODE, 8'h87);
		`CHK(sck_oe_n, 1'b1)
		repeat (16)
		begin
			repeat (10) @(posedge pclk);
			ext_sck <= ~ext_sck;
		end
		repeat (10) @(posedge pclk);
		`CHK(dones - d0, 1)
		`CHK(prx_n, 7'd8)
		`CHK(prx[63:56], 8'hc3)
		// Reset in mid-run must bring the clock field back to internal
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		`CHK(serial_out, 1'b0)
		`CHK(sck_oe_n, 1'b1)
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		`CHK(sck_oe_n, 1'b0)
		rd(`CSBP_IDX_CNTW);
		`CHK(rv, 32'h0)
	endtask

	task automatic print_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge pclk);
		fails++;
		print_verdict();
	end

	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		t_reset();
		t_tx();
		t_rx();
		t_misc();
		t_hold();
		t_ext();
		print_verdict();
	end
endmodule

// ==== bench/csbp_peer.sv ====
`timescale 1ns/1ns

module csbp_peer (
	input  wire logic        pclk,
	input  wire logic        load,
	input  wire logic [63:0] tx_data,
	input  wire logic        sck_out,
	input  wire logic        serial_out,
	output logic             serial_in,
	output logic      [63:0] rx_q,
	output logic      [6:0]  rx_n
);
	logic [63:0] tx_q;
	logic        sck_d = 1'b1;
	logic [7:0]  idle_n = 8'h00;
	initial serial_in = 1'b1;
	always @(posedge pclk)
	begin
		sck_d <= sck_out;
		idle_n <= (sck_out & sck_d) ? idle_n + 8'h01 : 8'h00;
		if (load)
		begin
			tx_q <= tx_data;
			rx_n <= 7'h00;
		end
		else if (sck_d & !sck_out)
		begin
			serial_in <= tx_q[0];
			tx_q <= tx_q >> 1;
		end
		else if (!sck_d & sck_out)
		begin
			rx_q <= {serial_out, rx_q[63:1]};
			rx_n <= rx_n + 7'h01;
		end
		// Released line must not look like held data
		else if (idle_n > 8'h40)
			serial_in <= ~serial_in;
	end
endmodule

// ==== logic/csbp_clkgen.sv ====
`timescale 1ns/1ns
`include "csbp_regs.svh"

module csbp_clkgen (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       run,
	input  wire logic [2:0] sel,
	input  wire logic       low_src,
	input  wire logic       fs_rise,
	output logic            half_tick
);

	logic [11:0] pre_q;
	logic [3:0]  fs_cnt_q;
	logic [11:0] mask;
	logic        fc_hit;
	logic        fs_hit;

	function automatic logic [11:0] half_mask(input logic [2:0] s);
		case (s)
			3'h0: half_mask = `CSBP_DIV_M0;
			3'h1: half_mask = `CSBP_DIV_M1;
			3'h2: half_mask = `CSBP_DIV_M2;
			3'h3: half_mask = `CSBP_DIV_M3;
			3'h4: half_mask = `CSBP_DIV_M4;
			3'h5: half_mask = `CSBP_DIV_M5;
			default: half_mask = 12'h000;
		endcase
	endfunction

	// Reserved and external codes give no internal tick [RULE_09]
	assign mask = half_mask(sel);
	assign fc_hit = run && !low_src && (mask != 12'h000)
		&& ((pre_q & mask) == mask);
	// Low-frequency source only on code 000; others stay silent [RULE_10]
	assign fs_hit = run && low_src && (sel == `CSBP_SCK_LOWF)
		&& fs_rise && (fs_cnt_q == `CSBP_FS_HALF);

	// Prescaler held at zero when idle so the first half period is whole
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pre_q     <= 12'h000;
			fs_cnt_q  <= 4'h0;
			half_tick <= 1'b0;
		end
		else
		begin
			pre_q     <= run ? pre_q + 12'h001 : 12'h000;
			fs_cnt_q  <= !run ? 4'h0 : fs_rise ? fs_cnt_q + 4'h1 : fs_cnt_q;
			half_tick <= fc_hit || fs_hit;
		end
	end

endmodule

// ==== logic/csbp_pkg.sv ====
package csbp_pkg;

	typedef enum logic [1:0] {
		CSBP_IDLE  = 2'b00,
		CSBP_SHIFT = 2'b01,
		CSBP_GAP   = 2'b10,
		CSBP_HOLD  = 2'b11
	} csbp_state_type;

	typedef enum logic [2:0] {
		CSBP_TX8  = 3'b000,
		CSBP_TX4  = 3'b010,
		CSBP_TRX8 = 3'b100,
		CSBP_RX8  = 3'b101,
		CSBP_RX4  = 3'b110
	} csbp_mode_type;

endpackage

// ==== logic/csbp_regs.svh ====
`ifndef CSBP_REGS_SVH
`define CSBP_REGS_SVH

// Register indices; byte address is four times the index
`define CSBP_IDX_MODE 6'h26
`define CSBP_IDX_CNTW 6'h27
`define CSBP_IDX_BUF0 6'h28
`define CSBP_IDX_BUF7 6'h2f
`define CSBP_IDX_CFG 6'h30

// Reset values
`define CSBP_MODE_RST 8'h00
`define CSBP_CNTW_RST 5'h00
`define CSBP_CFG_RST 2'h0

// Field positions
`define CSBP_BIT_START 7
`define CSBP_BIT_ABORT 6
`define CSBP_BIT_ACTIVE 7
`define CSBP_BIT_SHIFTING 6
`define CSBP_BIT_DIVOPT 0
`define CSBP_BIT_SLOW 1

// Clock select codes
`define CSBP_SCK_LOWF 3'h0
`define CSBP_SCK_EXT 3'h7

// Half-period masks on the pclk prescaler, fc/2^13 down to fc/2^4
`define CSBP_DIV_M0 12'hfff
`define CSBP_DIV_M1 12'h07f
`define CSBP_DIV_M2 12'h03f
`define CSBP_DIV_M3 12'h01f
`define CSBP_DIV_M4 12'h00f
`define CSBP_DIV_M5 12'h007
// fs/2^5: toggle after 16 low-frequency edges
`define CSBP_FS_HALF 4'hf

// Last bit index of a word, and half periods of one 8-bit data time
`define CSBP_LAST8 3'h7
`define CSBP_LAST4 3'h3
`define CSBP_GAP_UNIT 7'h10

`endif

// ==== logic/csbp_top.sv ====
// Summary of operation
// RULE_01 - Eight-entry buffer serves transmit and receive, up to 64 bits
// RULE_02 - Buffer entries sit at consecutive indices, one byte or nibble each
// RULE_03 - Word-count field sets how many entries one start moves
// RULE_04 - Done pulse raised after the programmed word count has moved
// RULE_05 - Internal clock, 8-bit receive modes: fixed wait after each word
// RULE_06 - Control bit 7 written 1 starts, written 0 requests stop
// RULE_07 - Control bit 6 written 1 aborts; it clears itself afterwards
// RULE_08 - Mode field selects 8/4-bit transmit, receive, transmit-receive
// RULE_09 - Clock field selects fc divided by 2^13..2^4, or external clock
// RULE_10 - Divider option or slow mode: code 000 gives fs/2^5 only
// RULE_11 - Software stops and aborts before changing mode or clock
// RULE_12 - Software writes control registers with whole writes only
// RULE_13 - Separate readable status register reports running state; status here is read at the count/wait index
// RULE_14 - Link uses serial out, serial in and a serial clock line
// RULE_15 - Transmit shifts on clock falling edge, receive samples on rising
// RULE_16 - LSB first; 4-bit mode uses low nibble, receives zero upper nibble
// RULE_17 - Status holds transfer-active and shift-active flags
// RULE_18 - Count codes mean 1 to 8 words; wait codes 1,2,4,8 data times
// RULE_19 - Reset clears control fields and keeps serial clock idle high
// RULE_20 - Stop finishes the current block, then goes idle until next start
`timescale 1ns/1ns
`include "csbp_regs.svh"

module csbp_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             serial_out,
	input  wire logic        serial_in,
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe_n,
	input  wire logic        low_freq_clock,
	output logic             serial_done_interrupt
);

	csbp_pkg::csbp_state_type state_q;

	logic [2:0]  s1_q;
	logic [2:0]  s2_q;
	logic [2:0]  s3_q;
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;
	logic        start_q;
	logic        abort_q;
	logic [2:0]  mode_q;
	logic [2:0]  sck_sel_q;
	logic [2:0]  count_q;
	logic [1:0]  wait_q;
	logic        div_opt_q;
	logic        slow_q;
	logic [7:0]  dbuf_q [8];
	logic [2:0]  word_q;
	logic [2:0]  bit_q;
	logic [7:0]  sh_q;
	logic [6:0]  gap_q;
	logic        sck_q;
	logic        so_q;
	logic        oe_n_q;
	logic        irq_q;

	logic        si_s;
	logic        ext_fall;
	logic        ext_rise;
	logic        fs_rise;
	logic        acc_wait;
	logic        acc_done;
	logic [5:0]  idx;
	logic [2:0]  buf_sel;
	logic        hit_mode;
	logic        hit_cntw;
	logic        hit_buf;
	logic        hit_cfg;
	logic        mapped;
	logic        wr_mode;
	logic        wr_cntw;
	logic        wr_buf;
	logic        wr_cfg;
	logic [7:0]  status;
	logic [31:0] rdata_w;
	logic        internal;
	logic        half_tick;
	logic        fall_ev;
	logic        rise_ev;
	logic        four_bit;
	logic        is_rx;
	logic [2:0]  last_bit;
	logic        word_end;
	logic        block_end;
	logic        store_en;
	logic [7:0]  next_sh;
	logic [7:0]  rx_word;
	logic        wait_on;
	logic [6:0]  gap_load;
	logic        resume;
	logic        go;

	function automatic logic mode_ok(input logic [2:0] m);
		mode_ok = (m == csbp_pkg::CSBP_TX8) || (m == csbp_pkg::CSBP_TX4)
			|| (m == csbp_pkg::CSBP_TRX8) || (m == csbp_pkg::CSBP_RX8)
			|| (m == csbp_pkg::CSBP_RX4);
	endfunction

	function automatic logic mode_rx(input logic [2:0] m);
		mode_rx = (m == csbp_pkg::CSBP_TRX8) || (m == csbp_pkg::CSBP_RX8)
			|| (m == csbp_pkg::CSBP_RX4);
	endfunction

	function automatic logic [6:0] gap_len(input logic [1:0] w);
		case (w)
			2'h0: gap_len = 7'h00;
			2'h1: gap_len = `CSBP_GAP_UNIT;
			2'h2: gap_len = 7'(3 * `CSBP_GAP_UNIT);
			default: gap_len = 7'(7 * `CSBP_GAP_UNIT);
		endcase
	endfunction

	// Pins pass three flops; edges are taken from the second and third only
	// Clock bit resets high, its idle level, so no false edge follows reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_q <= 3'h2;
			s2_q <= 3'h2;
			s3_q <= 3'h2;
		end
		else
		begin
			s1_q <= {serial_in, sck_in, low_freq_clock};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign si_s     = s2_q[2];
	assign ext_fall = s3_q[1] && !s2_q[1];
	assign ext_rise = !s3_q[1] && s2_q[1];
	assign fs_rise  = !s3_q[0] && s2_q[0];

	// APB: one wait state, so every output comes from a flop
	assign acc_wait = psel && penable && !pready_q;
	assign acc_done = psel && penable && pready_q;
	assign idx      = paddr[7:2];
	assign buf_sel  = idx[2:0];
	assign hit_mode = idx == `CSBP_IDX_MODE;
	assign hit_cntw = idx == `CSBP_IDX_CNTW;
	// Entries at consecutive indices, lowest first [RULE_02]
	assign hit_buf  = (idx >= `CSBP_IDX_BUF0) && (idx <= `CSBP_IDX_BUF7);
	assign hit_cfg  = idx == `CSBP_IDX_CFG;
	assign mapped   = hit_mode || hit_cntw || hit_buf || hit_cfg;
	// Whole-word writes only; mode and count/wait do not read back to modify [RULE_12]
	assign wr_mode  = acc_done && pwrite && hit_mode;
	assign wr_cntw  = acc_done && pwrite && hit_cntw;
	assign wr_buf   = acc_done && pwrite && hit_buf;
	assign wr_cfg   = acc_done && pwrite && hit_cfg;

	// Status shares the count/wait index but is read-only [RULE_13] [RULE_17]
	assign status = {state_q != csbp_pkg::CSBP_IDLE,
		state_q == csbp_pkg::CSBP_SHIFT, 6'h00};
	assign rdata_w = hit_cntw ? {24'h000000, status}
		: hit_buf ? {24'h000000, dbuf_q[buf_sel]}
		: hit_cfg ? {30'h00000000, slow_q, div_opt_q}
		: 32'h00000000;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h00000000;
		end
		else
		begin
			pready_q  <= acc_wait;
			pslverr_q <= acc_wait && !mapped;
			prdata_q  <= acc_wait ? rdata_w : prdata_q;
		end
	end

	// Mode and clock are taken as written; software stops first [RULE_11]
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			{start_q, abort_q, mode_q, sck_sel_q} <= `CSBP_MODE_RST; // [RULE_19]
			{wait_q, count_q} <= `CSBP_CNTW_RST;
			{slow_q, div_opt_q} <= `CSBP_CFG_RST;
		end
		else
		begin
			if (wr_mode)
			begin
				start_q   <= pwdata[`CSBP_BIT_START]; // [RULE_06]
				abort_q   <= pwdata[`CSBP_BIT_ABORT];
				mode_q    <= pwdata[5:3];
				sck_sel_q <= pwdata[2:0];
			end
			else if (abort_q)
				abort_q <= 1'b0; // [RULE_07]
			if (wr_cntw)
				{wait_q, count_q} <= pwdata[4:0]; // [RULE_18]
			if (wr_cfg)
			begin
				div_opt_q <= pwdata[`CSBP_BIT_DIVOPT];
				slow_q    <= pwdata[`CSBP_BIT_SLOW];
			end
		end
	end

	// Engine store beats a bus write to the same entry [RULE_01]
	for (genvar gi = 0; gi < 8; gi++)
	begin : g_buf
		logic eng_we;
		logic bus_we;
		assign eng_we = store_en && (word_q == 3'(gi));
		assign bus_we = wr_buf && (buf_sel == 3'(gi));
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
				dbuf_q[gi] <= 8'h00;
			else if (eng_we)
				dbuf_q[gi] <= rx_word;
			else if (bus_we)
				dbuf_q[gi] <= pwdata[7:0];
		end
	end

	assign internal = sck_sel_q != `CSBP_SCK_EXT;

	csbp_clkgen u_clkgen (
		.pclk      (pclk),
		.presetn   (presetn),
		.run       (state_q != csbp_pkg::CSBP_IDLE),
		.sel       (sck_sel_q),
		.low_src   (div_opt_q || slow_q),
		.fs_rise   (fs_rise),
		.half_tick (half_tick)
	);

	// Falling edge drives data, rising edge samples [RULE_15]
	assign fall_ev  = internal ? (half_tick && sck_q) : ext_fall;
	assign rise_ev  = internal ? (half_tick && !sck_q) : ext_rise;
	assign four_bit = (mode_q == csbp_pkg::CSBP_TX4)
		|| (mode_q == csbp_pkg::CSBP_RX4); // [RULE_08]
	assign is_rx    = mode_rx(mode_q);
	assign last_bit = four_bit ? `CSBP_LAST4 : `CSBP_LAST8;
	assign word_end = (state_q == csbp_pkg::CSBP_SHIFT) && rise_ev
		&& (bit_q == last_bit);
	assign block_end = word_end && (word_q == count_q); // [RULE_03]
	assign store_en = word_end && is_rx;
	// LSB first; a nibble lands in the top half and is moved down [RULE_16]
	assign next_sh  = {si_s, sh_q[7:1]};
	assign rx_word  = four_bit ? {4'h0, next_sh[7:4]} : next_sh;
	// Wait only with internal clock in the 8-bit receive modes [RULE_05]
	assign wait_on  = internal && (wait_q != 2'h0)
		&& ((mode_q == csbp_pkg::CSBP_TRX8)
		|| (mode_q == csbp_pkg::CSBP_RX8));
	assign gap_load = gap_len(wait_q); // [RULE_18]
	// A full block with start still set pauses until software touches the last entry used or clears start
	assign resume   = acc_done && hit_buf && (buf_sel == count_q);
	// Reserved modes never start, which keeps the shifter quiet
	assign go = (state_q == csbp_pkg::CSBP_IDLE) && start_q && !abort_q
		&& mode_ok(mode_q);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= csbp_pkg::CSBP_IDLE;
			word_q  <= 3'h0;
			bit_q   <= 3'h0;
			sh_q    <= 8'h00;
			gap_q   <= 7'h00;
			sck_q   <= 1'b1; // [RULE_19]
			so_q    <= 1'b0;
			irq_q   <= 1'b0;
			oe_n_q  <= 1'b1;
		end
		else
		begin
			irq_q  <= block_end && !abort_q; // [RULE_04]
			oe_n_q <= !internal; // [RULE_14]
			if (abort_q)
			begin
				state_q <= csbp_pkg::CSBP_IDLE; // [RULE_07]
				sck_q   <= 1'b1;
			end
			else
			begin
				unique case (state_q)
					csbp_pkg::CSBP_IDLE:
						if (go)
						begin
							state_q <= csbp_pkg::CSBP_SHIFT; // [RULE_06]
							word_q  <= 3'h0;
							bit_q   <= 3'h0;
							sh_q    <= dbuf_q[0];
						end
					csbp_pkg::CSBP_SHIFT:
					begin
						if (fall_ev)
						begin
							so_q  <= sh_q[0]; // [RULE_15]
							sck_q <= internal ? 1'b0 : sck_q;
						end
						if (rise_ev)
						begin
							sh_q  <= next_sh;
							sck_q <= 1'b1;
							bit_q <= bit_q + 3'h1;
						end
						if (word_end)
						begin
							bit_q <= 3'h0;
							if (block_end)
								state_q <= start_q ? csbp_pkg::CSBP_HOLD
									: csbp_pkg::CSBP_IDLE; // [RULE_20]
							else
							begin
								word_q <= word_q + 3'h1;
								sh_q   <= dbuf_q[word_q + 3'h1];
								if (wait_on)
								begin
									state_q <= csbp_pkg::CSBP_GAP; // [RULE_05]
									gap_q   <= gap_load;
								end
							end
						end
					end
					csbp_pkg::CSBP_GAP:
						if (half_tick)
						begin
							gap_q <= gap_q - 7'h01;
							if (gap_q == 7'h01)
								state_q <= csbp_pkg::CSBP_SHIFT;
						end
					csbp_pkg::CSBP_HOLD:
						if (!start_q || resume)
							state_q <= csbp_pkg::CSBP_IDLE; // [RULE_20]
				endcase
			end
		end
	end

	assign prdata     = prdata_q;
	assign pready     = pready_q;
	assign pslverr    = pslverr_q;
	assign serial_out = so_q;
	assign sck_out    = sck_q;
	assign sck_oe_n   = oe_n_q;
	assign serial_done_interrupt = irq_q;

	property p_abort_done;
		@(posedge pclk) disable iff (!presetn)
		abort_q && !wr_mode |=> !abort_q && state_q == csbp_pkg::CSBP_IDLE;
	endproperty
	a_abort_done: assert property (p_abort_done) // [RULE_07]
		else $error("abort bit did not clear");

	property p_start;
		@(posedge pclk) disable iff (!presetn)
		go |=> state_q == csbp_pkg::CSBP_SHIFT && word_q == 3'h0;
	endproperty
	a_start: assert property (p_start) // [RULE_06]
		else $error("start did not begin a block");

	property p_irq_cause;
		@(posedge pclk) disable iff (!presetn)
		irq_q |-> $past(state_q) == csbp_pkg::CSBP_SHIFT
			&& $past(word_q) == $past(count_q);
	endproperty
	a_irq_cause: assert property (p_irq_cause) // [RULE_04]
		else $error("done pulse without full block");

	property p_count_bound;
		@(posedge pclk) disable iff (!presetn)
		state_q != csbp_pkg::CSBP_IDLE |-> word_q <= count_q;
	endproperty
	a_count_bound: assert property (p_count_bound) // [RULE_03]
		else $error("entry beyond word count used");

	property p_nibble_zero;
		@(posedge pclk) disable iff (!presetn)
		store_en && four_bit |=> dbuf_q[$past(word_q)][7:4] == 4'h0;
	endproperty
	a_nibble_zero: assert property (p_nibble_zero) // [RULE_16]
		else $error("upper nibble not cleared");

	property p_sck_idle;
		@(posedge pclk) disable iff (!presetn)
		state_q != csbp_pkg::CSBP_SHIFT |-> sck_q;
	endproperty
	a_sck_idle: assert property (p_sck_idle) // [RULE_19]
		else $error("serial clock low outside shifting");

	property p_so_edge;
		@(posedge pclk) disable iff (!presetn)
		$changed(so_q) |-> $past(fall_ev);
	endproperty
	a_so_edge: assert property (p_so_edge) // [RULE_15]
		else $error("data out changed off the falling edge");

	property p_gap_len;
		@(posedge pclk) disable iff (!presetn)
		$rose(state_q == csbp_pkg::CSBP_GAP) |->
			gap_q == 7'(((1 << wait_q) - 1) * `CSBP_GAP_UNIT) && wait_on;
	endproperty
	a_gap_len: assert property (p_gap_len) // [RULE_05]
		else $error("wrong wait length");

	property p_stop;
		@(posedge pclk) disable iff (!presetn)
		block_end && !start_q && !abort_q |=>
			state_q == csbp_pkg::CSBP_IDLE ##1 state_q == csbp_pkg::CSBP_IDLE;
	endproperty
	a_stop: assert property (p_stop) // [RULE_20]
		else $error("stopped block did not go idle");

endmodule
